/* include/ram_power_defs.vh */
// constants for the ram section power register block
// assumes a plain register port with 32-bit words and byte offsets
// Summary of operation
// [R1] bank5 power bit per section, 1 on
// [R2] powered section always keeps its contents
// [R3] off section retained only if retention set
// [R4] system off forces every section off
// [R5] bank5 retention bit per section, 1 keeps
// [R6] bank5 power register decoded at 0x950
// [R7] bank4 clear write 1 powers section off
// [R8] bank4 clear write 1 drops retention bit
// [R9] set and clear reads return power register
// [R10] set register write 1 powers section on
`ifndef RAM_POWER_DEFS_VH
`define RAM_POWER_DEFS_VH
`define BANK4_POWER_OFS   12'h940
`define BANK4_SET_OFS     12'h944
`define BANK4_CLEAR_OFS   12'h948
`define BANK5_POWER_OFS   12'h950
`define BANK5_SET_OFS     12'h954
`define BANK5_CLEAR_OFS   12'h958
`define POWER_RESET_VAL   32'h0000ffff
`define POWER_FIELD_LSB   0
`define RETAIN_FIELD_LSB  16
`endif

/* src/ram_section_power_control.v */
// ram section power and retention registers for banks 4 and 5
// assumes a one-cycle strobe register port, read data one cycle later
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/1ns
`include "ram_power_defs.vh"
module ram_section_power_control #(
  parameter SECTIONS = 16
) (
  input  wire                    core_clk,       // system clock
  input  wire                    srst,           // synchronous reset, active high
  input  wire [11:0]             reg_addr,       // byte address
  input  wire [31:0]             reg_wdata,      // write data
  input  wire                    reg_wr,         // write strobe
  input  wire                    reg_rd,         // read strobe
  output reg  [31:0]             reg_rdata,      // read data, cycle after strobe
  input  wire                    system_off,     // deepest sleep mode request
  output wire [SECTIONS-1:0]     bank4_power_en, // bank 4 section full power
  output wire [SECTIONS-1:0]     bank4_retain_en,// bank 4 section retention supply
  output wire [SECTIONS-1:0]     bank5_power_en, // bank 5 section full power
  output wire [SECTIONS-1:0]     bank5_retain_en // bank 5 section retention supply
);
  reg  [31:0] bank4_power_r;
  reg  [31:0] bank5_power_r;
  reg  [31:0] bank4_power_nxt;
  reg  [31:0] bank5_power_nxt;
  reg  [31:0] rdata_nxt;
  reg         off_meta_r;
  reg         off_sync_r;

  // system_off comes from the power manager outside this clock domain
  always @(posedge core_clk) begin
    if (srst) begin
      off_meta_r <= 1'b0;
      off_sync_r <= 1'b0;
    end else begin
      off_meta_r <= system_off;
      off_sync_r <= off_meta_r;
    end
  end

  always @* begin
    bank4_power_nxt = bank4_power_r;
    bank5_power_nxt = bank5_power_r;
    if (reg_wr) begin
      case (reg_addr)
        `BANK4_POWER_OFS: bank4_power_nxt = reg_wdata;
        `BANK4_SET_OFS:   bank4_power_nxt = bank4_power_r | reg_wdata;  // R10
        `BANK4_CLEAR_OFS: bank4_power_nxt = bank4_power_r & ~reg_wdata; // R7 R8
        `BANK5_POWER_OFS: bank5_power_nxt = reg_wdata;                  // R1 R5 R6
        `BANK5_SET_OFS:   bank5_power_nxt = bank5_power_r | reg_wdata;  // R10
        `BANK5_CLEAR_OFS: bank5_power_nxt = bank5_power_r & ~reg_wdata;
        default: begin
          bank4_power_nxt = bank4_power_r;
        end
      endcase
    end
  end

  always @* begin
    case (reg_addr)
      `BANK4_POWER_OFS,
      `BANK4_SET_OFS,
      `BANK4_CLEAR_OFS: rdata_nxt = bank4_power_r; // R9
      `BANK5_POWER_OFS,
      `BANK5_SET_OFS,
      `BANK5_CLEAR_OFS: rdata_nxt = bank5_power_r; // R9
      default:          rdata_nxt = 32'h00000000;
    endcase
  end

  always @(posedge core_clk) begin
    if (srst) begin
      bank4_power_r <= `POWER_RESET_VAL;
      bank5_power_r <= `POWER_RESET_VAL;
      reg_rdata     <= 32'h00000000;
    end else begin
      bank4_power_r <= bank4_power_nxt;
      bank5_power_r <= bank5_power_nxt;
      reg_rdata     <= reg_rd ? rdata_nxt : 32'h00000000;
    end
  end

  // per-section enables; retention supply follows power or the retention bit
  genvar i;
  generate
    for (i = 0; i < SECTIONS; i = i + 1) begin : g_sec
      assign bank4_power_en[i]  = bank4_power_r[`POWER_FIELD_LSB+i] & ~off_sync_r; // R4
      assign bank5_power_en[i]  = bank5_power_r[`POWER_FIELD_LSB+i] & ~off_sync_r; // R4
      assign bank4_retain_en[i] = bank4_power_en[i] |
                                  bank4_power_r[`RETAIN_FIELD_LSB+i];              // R2 R3
      assign bank5_retain_en[i] = bank5_power_en[i] |
                                  bank5_power_r[`RETAIN_FIELD_LSB+i];              // R2 R3
    end
  endgenerate
endmodule

/* bench/ram_power_properties.sv */
// port checks for the ram section power block
// bound to the design top, one clock domain
`timescale 1ns/1ns
module ram_power_properties #(parameter SECTIONS=16)(input wire core_clk,srst,reg_wr,reg_rd,
  system_off,input [11:0] reg_addr,input [31:0] reg_wdata,reg_rdata,
  input [SECTIONS-1:0] bank4_power_en,bank4_retain_en,bank5_power_en,bank5_retain_en);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  a_on_kept: assert property (
    !(bank4_power_en&~bank4_retain_en|bank5_power_en&~bank5_retain_en)) else $error("k");
  a_off_kill: assert property (system_off[*3]|->!(bank4_power_en|bank5_power_en))
    else $error("o");
  a_b5_write: assert property ((!system_off)[*3]##0 reg_wr&&reg_addr==12'h950
    |=>bank5_power_en==$past(reg_wdata[15:0])) else $error("w");
  a_b5_keep: assert property (reg_wr&&reg_addr==12'h950
    |=>bank5_retain_en==($past(reg_wdata[31:16])|bank5_power_en)) else $error("r");
  a_clr_off: assert property (reg_wr&&reg_addr==12'h948
    |=>!(bank4_power_en&$past(reg_wdata[15:0]))) else $error("c");
  a_clr_keep: assert property (reg_wr&&reg_addr==12'h948
    |=>!(bank4_retain_en&~bank4_power_en&$past(reg_wdata[31:16]))) else $error("d");
  a_set_on: assert property ((!system_off)[*3]##0 reg_wr&&reg_addr==12'h944
    |=>&(bank4_power_en|~$past(reg_wdata[15:0]))) else $error("s");
  a_read_back: assert property ((!system_off)[*3]##0 reg_rd&&reg_addr==12'h954
    |=>reg_rdata[15:0]==$past(bank5_power_en)) else $error("b");
endmodule
bind ram_section_power_control ram_power_properties #(.SECTIONS(SECTIONS)) u_chk(.*);

/* bench/ram_section_power_control_test.sv */
// bench for the ram section power registers
// drives every block input itself
`timescale 1ns/1ns
module ram_section_power_control_test;
  logic core_clk=0,srst=1,reg_wr=0,reg_rd=0,system_off=0;
  logic [11:0] reg_addr=0;
  logic [31:0] reg_wdata=0;
  wire [31:0] reg_rdata;
  wire [15:0] bank4_power_en,bank4_retain_en,bank5_power_en,bank5_retain_en;
  int n_errors=0,n_tests=0;
  ram_section_power_control DUT(.*);
  initial forever #25 core_clk=~core_clk;
  task ck(string s,logic [31:0] g,e); n_tests++;
    if (g!==e) begin n_errors++; $display("unexpected %s exp %h got %h",s,e,g); end endtask
  task rw(bit w,logic [11:0] a,logic [31:0] d);
    @(posedge core_clk) {reg_wr,reg_rd,reg_addr,reg_wdata}<={w,!w,a,d};
    @(posedge core_clk) {reg_wr,reg_rd}<=2'h0; #1; endtask
  task end_of_test; $display("%0d checks %0d errors",n_tests,n_errors);
    if (n_errors==0&&n_tests>0) $display("Finished cleanly"); else $display("Finished with errors");
    $finish; endtask
  task t_b5; rw(1,12'h950,32'hf00f0f); rw(0,12'h954,0); ck("rd",reg_rdata,32'hf00f0f);
    ck("b5",{bank5_retain_en,bank5_power_en},32'hfff0f0f); $display("b5 done"); endtask
  task t_b4; rw(1,12'h944,32'h38000); rw(1,12'h948,32'h10003); rw(0,12'h948,0);
    ck("rd",reg_rdata,32'h2fffc); rw(0,12'h94c,0); ck("gap",reg_rdata,32'h0);
    $display("b4 done"); endtask
  task t_off; @(posedge core_clk) system_off<=1; repeat(3) @(posedge core_clk); #1;
    ck("off",{bank4_retain_en|bank4_power_en,bank5_retain_en|bank5_power_en},32'h200f0);
    $display("off done"); endtask
  task t_b5sc; @(posedge core_clk) system_off<=0; repeat(2) @(posedge core_clk); #1;
    ck("back",bank5_power_en,32'h0f0f);
    rw(1,12'h954,32'h1f000); rw(1,12'h958,32'hf000ff); rw(0,12'h958,0);
    ck("rd5",reg_rdata,32'h1ff00);
    @(posedge core_clk) #1 ck("rd0",reg_rdata,32'h0);
    ck("sc",{bank5_retain_en,bank5_power_en},32'hff01ff00);
    $display("b5 set clear done"); endtask
  initial begin #20000 n_errors++; end_of_test; end
  initial begin repeat(3) @(posedge core_clk); srst<=0; t_b5; t_b4; t_off; t_b5sc; end_of_test; end
endmodule
